//--- rtl/sdms_top.sv
// Special drive mode selector: step-direction, analog speed and test run
`timescale 1ns/1ps
`include "sdms_map.svh"

// Notes on behaviour
// - Special modes run only when the stored activation value is 2.
// - 00h-07h open loop, 08h-0Fh closed; pairs: step, test, then four analog.
// - Test run turns at 30 rpm; even code clockwise, odd counterclockwise.
// - Analog 4/5 take direction input, 6/7 joystick; even 1000, odd 100 rpm.
// - New configuration acts only after it is stored and the controller restarts.
// - With special modes on, power state follows enable; control word ignored.
// - Digital input 1 is the enable input.
// - Step-direction mode forwards step and direction; source drives all three pins.
// - Analog mode runs velocity mode and writes the speed to target velocity.
// - Maximum is 100 or 1000 rpm, rescaled by the scaling factor pair.
// - Normal analog maps full scale to maximum, sense from direction input.
// - Normal analog gives zero speed from 0 V to 20 mV.
// - Joystick: half scale is zero, below negative, above positive.
// - Joystick gives zero speed within 20 mV of half scale.
// - Test run turns only while enable is asserted.

module sdms_top (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Stored configuration, read once after restart
    input wire logic [7:0] nv_activation,
    input wire logic [7:0] nv_mode,
    // Scaling factor numerator and divisor
    input wire logic [15:0] scale_num,
    input wire logic [15:0] scale_den,
    // Fieldbus control word state requests
    input wire logic cw_req_valid,
    input wire logic cw_req_enable,
    // Pins from the pulse or setpoint source
    input wire logic enable_in,
    input wire logic step_in,
    input wire logic dir_in,
    // Analog converter, same clock
    input wire logic [11:0] adc_value,
    input wire logic adc_valid,
    // Mode status
    output logic special_active,
    output logic closed_loop,
    output sdms_pkg::sdms_drive_e drive_mode,
    output logic op_enabled,
    // Step-direction engine
    output logic step_pulse,
    output logic step_dir,
    // Target velocity, rpm two's complement
    output logic [31:0] target_vel,
    output logic target_vel_wr
);

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    sdms_pkg::sdms_top_s st_reg;
    sdms_pkg::sdms_top_s st_next;

    logic div_done;
    logic [31:0] div_result;

    sdms_pkg::sdms_kind_e kind;
    logic odd_code;
    logic step_rise;

    assign kind = sdms_pkg::sdms_kind_e'(st_reg.mode[`SDMS_KIND_LSB +: 2]);
    assign odd_code = st_reg.mode[`SDMS_ODD_BIT];
    assign step_rise = st_reg.stp_s2 && !st_reg.stp_s3;

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        logic zero;
        logic [31:0] test_vel;
        logic [11:0] lo_edge;
        logic [11:0] hi_edge;
        zero = 1'b0;
        test_vel = 32'h0;
        lo_edge = `SDMS_ADC_MID - `SDMS_DEAD_CNT;
        hi_edge = `SDMS_ADC_MID + `SDMS_DEAD_CNT;
        st_next = st_reg;
        st_next.start = 1'b0;
        st_next.vel_wr = 1'b0;
        st_next.step_pulse = 1'b0;

        // Pin synchronisers
        st_next.en_s1 = enable_in;
        st_next.en_s2 = st_reg.en_s1;
        st_next.stp_s1 = step_in;
        st_next.stp_s2 = st_reg.stp_s1;
        st_next.stp_s3 = st_reg.stp_s2;
        st_next.dir_s1 = dir_in;
        st_next.dir_s2 = st_reg.dir_s1;

        // Stored values are caught once after restart and then frozen
        if (!st_reg.loaded) begin
            st_next.loaded = 1'b1;
            st_next.act = nv_activation;
            st_next.mode = nv_mode;
            st_next.special = (nv_activation == `SDMS_ACT_ON) && (nv_mode <= `SDMS_MODE_LAST);
            st_next.closed = nv_mode[`SDMS_CLOSED_BIT];
        end

        // Power state
        if (st_reg.special) begin
            st_next.op_en = st_reg.en_s2;
        end else begin
            if (cw_req_valid) begin
                st_next.cw_en = cw_req_enable;
            end
            st_next.op_en = st_reg.cw_en;
        end

        if (!st_reg.special) begin
            st_next.drive = sdms_pkg::SDMS_DRV_NONE;
        end else begin
            case (kind)
                sdms_pkg::SDMS_K_STEP: begin
                    st_next.drive = sdms_pkg::SDMS_DRV_STEP;
                    st_next.step_pulse = st_reg.op_en && step_rise;
                    st_next.step_dir = st_reg.dir_s2;
                end
                sdms_pkg::SDMS_K_TEST: begin
                    st_next.drive = sdms_pkg::SDMS_DRV_VEL;
                    test_vel = odd_code ? (32'h0 - `SDMS_TEST_RPM) : `SDMS_TEST_RPM;
                    st_next.target = st_reg.op_en ? test_vel : 32'h0;
                    st_next.vel_wr = (st_next.target != st_reg.target);
                end
                default: begin
                    st_next.drive = sdms_pkg::SDMS_DRV_VEL;
                    st_next.maxr = odd_code ? `SDMS_MAX_LO_RPM : `SDMS_MAX_HI_RPM;
                    if (!st_reg.op_en) begin
                        // Result in flight is dropped, but busy waits for done so the next enable is not locked out
                        st_next.target = 32'h0;
                        st_next.vel_wr = (st_reg.target != 32'h0);
                        if (div_done) begin
                            st_next.busy = 1'b0;
                        end
                    end else if (st_reg.busy) begin
                        if (div_done) begin
                            st_next.busy = 1'b0;
                            st_next.target = div_result;
                            st_next.vel_wr = 1'b1;
                        end
                    end else if (adc_valid) begin
                        if (kind == sdms_pkg::SDMS_K_NORM) begin
                            if (adc_value <= `SDMS_DEAD_CNT) begin
                                zero = 1'b1;
                            end
                            st_next.excess = adc_value - `SDMS_DEAD_CNT;
                            st_next.span = `SDMS_ADC_FS - `SDMS_DEAD_CNT;
                            st_next.neg = st_reg.dir_s2;
                        end else if (adc_value < lo_edge) begin
                            st_next.excess = lo_edge - adc_value;
                            st_next.span = lo_edge;
                            st_next.neg = 1'b1;
                        end else if (adc_value > hi_edge) begin
                            st_next.excess = adc_value - hi_edge;
                            st_next.span = `SDMS_ADC_FS - hi_edge;
                            st_next.neg = 1'b0;
                        end else begin
                            zero = 1'b1;
                        end
                        if (zero) begin
                            st_next.target = 32'h0;
                            st_next.vel_wr = 1'b1;
                        end else begin
                            st_next.start = 1'b1;
                            st_next.busy = 1'b1;
                        end
                    end
                end
            endcase
        end

        // Busy only means something in analog mode
        if (!st_reg.special || kind == sdms_pkg::SDMS_K_STEP || kind == sdms_pkg::SDMS_K_TEST) begin
            st_next.busy = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------------
    // Scaler
    // ------------------------------------------------------------------------
    // Samples that arrive while the scaler is busy are dropped; only a sample taken while idle starts a computation
    sdms_scale u_scale (
        .clock(clock),
        .reset_n(reset_n),
        .start(st_reg.start),
        .excess(st_reg.excess),
        .span(st_reg.span),
        .max_rpm(st_reg.maxr),
        .scale_num(scale_num),
        .scale_den(scale_den),
        .negative(st_reg.neg),
        .done(div_done),
        .result(div_result)
    );

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign special_active = st_reg.special;
    assign closed_loop = st_reg.closed;
    assign drive_mode = st_reg.drive;
    assign op_enabled = st_reg.op_en;
    assign step_pulse = st_reg.step_pulse;
    assign step_dir = st_reg.step_dir;
    assign target_vel = st_reg.target;
    assign target_vel_wr = st_reg.vel_wr;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    a_act_gate: assert property (@(posedge clock) disable iff (!reset_n)
        st_reg.special |-> st_reg.act == `SDMS_ACT_ON && st_reg.mode <= `SDMS_MODE_LAST)
        else $error("Special mode active without activation code");

    a_loop_decode: assert property (@(posedge clock) disable iff (!reset_n)
        st_reg.loaded |-> closed_loop == st_reg.mode[`SDMS_CLOSED_BIT])
        else $error("Loop kind does not match mode code");

    a_cfg_frozen: assert property (@(posedge clock) disable iff (!reset_n)
        st_reg.loaded |=> $stable(st_reg.mode) && $stable(special_active))
        else $error("Configuration changed without restart");

    a_enable_rules: assert property (@(posedge clock) disable iff (!reset_n)
        special_active && $stable(special_active) |=> op_enabled == $past(st_reg.en_s2))
        else $error("Power state not following enable input");

    a_enable_drop: assert property (@(posedge clock) disable iff (!reset_n)
        special_active && !st_reg.en_s2 && !st_reg.en_s1 |=> ##1 !op_enabled && target_vel == 32'h0)
        else $error("Motor not stopped after enable dropped");

    a_test_speed: assert property (@(posedge clock) disable iff (!reset_n)
        special_active && kind == sdms_pkg::SDMS_K_TEST && op_enabled |=>
        target_vel == (odd_code ? 32'h0 - `SDMS_TEST_RPM : `SDMS_TEST_RPM))
        else $error("Test run speed wrong");

    a_step_forward: assert property (@(posedge clock) disable iff (!reset_n)
        special_active && kind == sdms_pkg::SDMS_K_STEP && op_enabled && step_rise |=> step_pulse)
        else $error("Step edge not forwarded");

    a_norm_dead: assert property (@(posedge clock) disable iff (!reset_n)
        special_active && kind == sdms_pkg::SDMS_K_NORM && op_enabled && !st_reg.busy && adc_valid
        && adc_value <= `SDMS_DEAD_CNT |=> target_vel == 32'h0 && target_vel_wr)
        else $error("Normal dead zone gave speed");

    a_joy_dead: assert property (@(posedge clock) disable iff (!reset_n)
        special_active && kind == sdms_pkg::SDMS_K_JOY && op_enabled && !st_reg.busy && adc_valid
        && adc_value >= `SDMS_ADC_MID - `SDMS_DEAD_CNT && adc_value <= `SDMS_ADC_MID + `SDMS_DEAD_CNT
        |=> target_vel == 32'h0 && target_vel_wr)
        else $error("Joystick dead zone gave speed");

    a_joy_sign: assert property (@(posedge clock) disable iff (!reset_n)
        special_active && kind == sdms_pkg::SDMS_K_JOY && op_enabled && !st_reg.busy && adc_valid
        && adc_value < `SDMS_ADC_MID - `SDMS_DEAD_CNT |=> st_reg.busy && st_reg.neg)
        else $error("Joystick low side not negative");

endmodule : sdms_top

//--- pkg/sdms_map.svh
// Constants of the special drive mode selector: codes, speeds, analog levels
`ifndef SDMS_MAP_SVH
`define SDMS_MAP_SVH

// ----------------------------------------------------------------------------
// Configuration codes
// ----------------------------------------------------------------------------
`define SDMS_ACT_ON 8'h02
`define SDMS_MODE_LAST 8'h0f
`define SDMS_CLOSED_BIT 3
`define SDMS_KIND_LSB 1
`define SDMS_ODD_BIT 0

// ----------------------------------------------------------------------------
// Speeds in rpm
// ----------------------------------------------------------------------------
`define SDMS_TEST_RPM 32'h0000001e
`define SDMS_MAX_HI_RPM 10'h3e8
`define SDMS_MAX_LO_RPM 10'h064

// ----------------------------------------------------------------------------
// Analog input: full scale, dead zone, joystick centre
// ----------------------------------------------------------------------------
`define SDMS_ADC_FS 12'hfff
`define SDMS_FS_MV 16'h2710
`define SDMS_DEAD_MV 16'h0014
`define SDMS_DEAD_CNT (12'(((32'(`SDMS_DEAD_MV) * 32'(`SDMS_ADC_FS)) / 32'(`SDMS_FS_MV))))
`define SDMS_ADC_MID (12'(`SDMS_ADC_FS >> 1))

// ----------------------------------------------------------------------------
// Divider
// ----------------------------------------------------------------------------
`define SDMS_DIV_STEPS 6'h26

`endif

//--- pkg/sdms_pkg.sv
// Types of the special drive mode selector
package sdms_pkg;

    typedef enum logic [1:0] {SDMS_DRV_NONE, SDMS_DRV_STEP, SDMS_DRV_VEL} sdms_drive_e;

    typedef enum logic [1:0] {SDMS_K_STEP, SDMS_K_TEST, SDMS_K_NORM, SDMS_K_JOY} sdms_kind_e;

    typedef enum logic {SDMS_DIV_IDLE, SDMS_DIV_RUN} sdms_div_e;

    typedef struct packed {
        sdms_div_e st;
        logic [5:0] cnt;
        logic [27:0] rem;
        logic [37:0] quo;
        logic [27:0] den;
        logic neg;
        logic done;
        logic [31:0] result;
    } sdms_div_s;

    typedef struct packed {
        logic en_s1;
        logic en_s2;
        logic stp_s1;
        logic stp_s2;
        logic stp_s3;
        logic dir_s1;
        logic dir_s2;
        logic loaded;
        logic [7:0] act;
        logic [7:0] mode;
        logic special;
        logic closed;
        sdms_drive_e drive;
        logic cw_en;
        logic op_en;
        logic step_pulse;
        logic step_dir;
        logic [31:0] target;
        logic vel_wr;
        logic busy;
        logic start;
        logic [11:0] excess;
        logic [11:0] span;
        logic [9:0] maxr;
        logic neg;
    } sdms_top_s;

endpackage : sdms_pkg

//--- rtl/sdms_scale.sv
// Analog excess to signed speed: excess * max * num / (span * den)
`timescale 1ns/1ps
`include "sdms_map.svh"

module sdms_scale (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Request
    input wire logic start,
    input wire logic [11:0] excess,
    input wire logic [11:0] span,
    input wire logic [9:0] max_rpm,
    input wire logic [15:0] scale_num,
    input wire logic [15:0] scale_den,
    input wire logic negative,
    // Answer
    output logic done,
    output logic [31:0] result
);

    sdms_pkg::sdms_div_s r_reg;
    sdms_pkg::sdms_div_s r_next;

    always_comb begin
        logic [11:0] ex_c;
        logic [15:0] den_c;
        logic [28:0] trial;
        logic ge;
        logic [37:0] q;
        ex_c = excess;
        den_c = scale_den;
        trial = 29'h0;
        ge = 1'b0;
        q = 38'h0;
        r_next = r_reg;
        r_next.done = 1'b0;
        case (r_reg.st)
            sdms_pkg::SDMS_DIV_IDLE: begin
                if (start) begin
                    // Clamp keeps the answer at or below the selected maximum times num/den
                    if (ex_c > span) begin
                        ex_c = span;
                    end
                    if (den_c == 16'h0000) begin
                        den_c = 16'h0001;
                    end
                    r_next.quo = 38'(ex_c) * 38'(max_rpm) * 38'(scale_num);
                    r_next.den = 28'(span) * 28'(den_c);
                    r_next.rem = 28'h0;
                    r_next.cnt = `SDMS_DIV_STEPS;
                    r_next.neg = negative;
                    r_next.st = sdms_pkg::SDMS_DIV_RUN;
                end
            end
            sdms_pkg::SDMS_DIV_RUN: begin
                trial = {r_reg.rem, r_reg.quo[37]};
                ge = (trial >= {1'b0, r_reg.den});
                r_next.rem = ge ? 28'(trial - {1'b0, r_reg.den}) : trial[27:0];
                q = {r_reg.quo[36:0], ge};
                r_next.quo = q;
                r_next.cnt = r_reg.cnt - 6'h01;
                if (r_reg.cnt == 6'h01) begin
                    r_next.done = 1'b1;
                    r_next.st = sdms_pkg::SDMS_DIV_IDLE;
                    r_next.result = r_reg.neg ? (32'h0 - {6'h00, q[25:0]}) : {6'h00, q[25:0]};
                end
            end
            default: begin
                r_next.st = sdms_pkg::SDMS_DIV_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign done = r_reg.done;
    assign result = r_reg.result;

    a_div_latency: assert property (@(posedge clock) disable iff (!reset_n)
        start && r_reg.st == sdms_pkg::SDMS_DIV_IDLE |-> ##39 done)
        else $error("Scaler answer not on time");

endmodule : sdms_scale

//--- dv/sdms_source.sv
// Model of the external pulse source and analog setpoint feeding the selector
`timescale 1ns/1ps

module sdms_source (
    // Clock
    input wire logic clock,
    // Pins
    output logic enable_in,
    output logic step_in,
    output logic dir_in,
    // Analog converter
    output logic [11:0] adc_value,
    output logic adc_valid
);
    initial begin
        enable_in = 1'b0;
        step_in = 1'b0;
        dir_in = 1'b0;
        adc_value = 12'h000;
        adc_valid = 1'b0;
    end

    task automatic pins(input logic en, input logic dir);
        @(posedge clock);
        enable_in <= en;
        dir_in <= dir;
    endtask : pins

    // Two cycles high and two low: half the fastest pin rate the synchroniser resolves
    task automatic steps(input int n);
        repeat (n) begin
            @(posedge clock);
            step_in <= 1'b1;
            repeat (2) @(posedge clock);
            step_in <= 1'b0;
            @(posedge clock);
        end
    endtask : steps

    // Value is not held past the strobe, so a stale read cannot pass
    task automatic sample(input logic [11:0] v);
        @(posedge clock);
        adc_value <= v;
        adc_valid <= 1'b1;
        @(posedge clock);
        adc_valid <= 1'b0;
        adc_value <= ~v;
    endtask : sample
endmodule : sdms_source

//--- dv/special_drive_mode_select_bench.sv
// Self-checking bench for the special drive mode selector
`timescale 1ns/1ps

module special_drive_mode_select_bench;
    logic clock;
    logic reset_n;
    logic [7:0] nv_activation;
    logic [7:0] nv_mode;
    logic [15:0] scale_num;
    logic [15:0] scale_den;
    logic cw_req_valid;
    logic cw_req_enable;
    logic enable_in;
    logic step_in;
    logic dir_in;
    logic [11:0] adc_value;
    logic adc_valid;
    logic special_active;
    logic closed_loop;
    sdms_pkg::sdms_drive_e drive_mode;
    logic op_enabled;
    logic step_pulse;
    logic step_dir;
    logic [31:0] target_vel;
    logic target_vel_wr;
    int bad_count;
    int checked;
    int pulses;
    logic [7:0] tcodes [4] = '{8'h02, 8'h03, 8'h0a, 8'h0b};

    sdms_top uut (
        .clock(clock), .reset_n(reset_n), .nv_activation(nv_activation), .nv_mode(nv_mode),
        .scale_num(scale_num), .scale_den(scale_den), .cw_req_valid(cw_req_valid),
        .cw_req_enable(cw_req_enable), .enable_in(enable_in), .step_in(step_in), .dir_in(dir_in),
        .adc_value(adc_value), .adc_valid(adc_valid), .special_active(special_active),
        .closed_loop(closed_loop), .drive_mode(drive_mode), .op_enabled(op_enabled),
        .step_pulse(step_pulse), .step_dir(step_dir), .target_vel(target_vel),
        .target_vel_wr(target_vel_wr)
    );

    sdms_source src (
        .clock(clock), .enable_in(enable_in), .step_in(step_in), .dir_in(dir_in),
        .adc_value(adc_value), .adc_valid(adc_valid)
    );

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    always @(posedge clock) begin
        if (step_pulse === 1'b1) begin
            pulses++;
        end
    end

    // ------------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude

    // Restart is the only way a new stored configuration is taken
    task automatic restart(input logic [7:0] act, input logic [7:0] mode, input int len);
        src.pins(1'b0, 1'b0);
        reset_n <= 1'b0;
        nv_activation <= act;
        nv_mode <= mode;
        repeat (len) @(posedge clock);
        reset_n <= 1'b1;
        repeat (5) @(posedge clock);
        #1;
    endtask : restart

    task automatic cw(input logic en);
        @(posedge clock);
        cw_req_valid <= 1'b1;
        cw_req_enable <= en;
        @(posedge clock);
        cw_req_valid <= 1'b0;
        repeat (3) @(posedge clock);
        #1;
    endtask : cw

    task automatic wait_op(input logic val);
        int i;
        for (i = 0; i < 8 && op_enabled !== val; i++) begin
            @(posedge clock);
            #1;
        end
        if (i == 8) begin
            bad_count++;
            $display("[ERR] %0t enable state not reached", $time);
            conclude();
        end
    endtask : wait_op

    task automatic wait_wr();
        int i;
        for (i = 0; i < 80; i++) begin
            #1;
            if (target_vel_wr === 1'b1) begin
                break;
            end
            @(posedge clock);
        end
        if (i == 80) begin
            bad_count++;
            $display("[ERR] %0t no speed write", $time);
            conclude();
        end
    endtask : wait_wr

    task automatic ana(input logic [11:0] v, input logic [31:0] exp);
        src.sample(v);
        wait_wr();
        check(target_vel, exp);
    endtask : ana

    task automatic scale(input logic [15:0] num, input logic [15:0] den);
        @(posedge clock);
        scale_num <= num;
        scale_den <= den;
    endtask : scale

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        reset_n = 1'b0;
        nv_activation = 8'h00;
        nv_mode = 8'h00;
        scale_num = 16'h0001;
        scale_den = 16'h0001;
        cw_req_valid = 1'b0;
        cw_req_enable = 1'b0;
        bad_count = 0;
        checked = 0;
        pulses = 0;
        restart(8'h02, 8'h00, 12);
        for (int m = 0; m < 16; m++) begin
            restart(8'h02, 8'(m), 2);
            check(special_active, 1'b1);
            check(closed_loop, m[3]);
            check(drive_mode, (m[2:1] == 2'h0) ? sdms_pkg::SDMS_DRV_STEP : sdms_pkg::SDMS_DRV_VEL);
        end
        restart(8'h01, 8'h04, 2);
        check(special_active, 1'b0);
        check(drive_mode, sdms_pkg::SDMS_DRV_NONE);
        restart(8'h02, 8'h10, 2);
        check(special_active, 1'b0);
        restart(8'h02, 8'h08, 2);
        nv_mode <= 8'h04;
        repeat (5) @(posedge clock);
        #1;
        check(closed_loop, 1'b1);
        check(drive_mode, sdms_pkg::SDMS_DRV_STEP);
        $display("test decode done");

        restart(8'h00, 8'h00, 2);
        cw(1'b1);
        check(op_enabled, 1'b1);
        cw(1'b0);
        check(op_enabled, 1'b0);
        restart(8'h02, 8'h09, 2);
        cw(1'b1);
        check(op_enabled, 1'b0);
        src.pins(1'b1, 1'b0);
        wait_op(1'b1);
        check(op_enabled, 1'b1);
        cw(1'b0);
        check(op_enabled, 1'b1);
        pulses = 0;
        src.steps(5);
        repeat (6) @(posedge clock);
        check(pulses, 5);
        src.pins(1'b1, 1'b1);
        repeat (5) @(posedge clock);
        #1;
        check(step_dir, 1'b1);
        src.pins(1'b0, 1'b1);
        wait_op(1'b0);
        pulses = 0;
        src.steps(3);
        repeat (6) @(posedge clock);
        check(pulses, 0);
        $display("test step done");

        foreach (tcodes[i]) begin
            restart(8'h02, tcodes[i], 2);
            src.pins(1'b1, 1'b0);
            wait_wr();
            check(target_vel, tcodes[i][0] ? 32'hffffffe2 : 32'h0000001e);
            src.pins(1'b0, 1'b0);
            wait_wr();
            check(target_vel, 32'h00000000);
            check(op_enabled, 1'b0);
        end
        $display("test run done");

        restart(8'h02, 8'h04, 2);
        src.pins(1'b1, 1'b0);
        wait_op(1'b1);
        ana(12'hfff, 32'h000003e8);
        ana(12'h008, 32'h00000000);
        ana(12'h7ff, 32'h000001f2);
        src.pins(1'b1, 1'b1);
        repeat (4) @(posedge clock);
        ana(12'hfff, 32'hfffffc18);
        scale(16'h0001, 16'h0002);
        ana(12'hfff, 32'hfffffe0c);
        scale(16'h0002, 16'h0001);
        restart(8'h02, 8'h05, 2);
        src.pins(1'b1, 1'b0);
        wait_op(1'b1);
        ana(12'hfff, 32'h000000c8);
        $display("test analog done");

        scale(16'h0001, 16'h0001);
        restart(8'h02, 8'h0e, 2);
        src.pins(1'b1, 1'b1);
        wait_op(1'b1);
        ana(12'h000, 32'hfffffc18);
        ana(12'h7ff, 32'h00000000);
        ana(12'hfff, 32'h000003e8);
        ana(12'h807, 32'h00000000);
        ana(12'h80c, 32'h00000002);
        ana(12'h7f2, 32'hfffffffe);
        restart(8'h02, 8'h0f, 2);
        src.pins(1'b1, 1'b0);
        wait_op(1'b1);
        ana(12'hfff, 32'h00000064);
        src.sample(12'hfff);
        src.pins(1'b0, 1'b0);
        repeat (50) @(posedge clock);
        #1;
        check(target_vel, 32'h00000000);
        src.pins(1'b1, 1'b0);
        wait_op(1'b1);
        ana(12'h000, 32'hffffff9c);
        $display("test joystick done");
        conclude();
    end
endmodule : special_drive_mode_select_bench
